// [design/pwpa_chan.sv]
// pwpa_chan: off/restart behaviour of one output channel, steered by its config byte.
// assumes run, stop-done, decay and fault inputs are synchronous to clk.
`timescale 1ns/1ps
module pwpa_chan
  import pwpa_pkg::*;
#(
  parameter int unsigned MIN_OFF_CYCLES = PWPA_MIN_OFF_CYCLES
)
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [7:0] cfg,
  input  wire logic       on_cmd,
  input  wire logic       fault_off,
  input  wire logic       stop_done,
  input  wire logic       vout_low,
  input  wire logic       share_clk_low,
  input  wire logic       fault_ext_low,
  input  wire logic       toff_max_hit,
  input  wire logic       clr_faults,
  output logic            out_en_q,
  output logic            run_low_q,
  output logic            alert_q,
  output logic            toff_warn_q,
  output pwpa_ch_state_t  state_q
);

  localparam logic [PWPA_CNT_W-1:0] MIN_OFF_LAST = PWPA_CNT_W'(MIN_OFF_CYCLES - 1);

  pwpa_ch_state_t          state_d;
  logic [PWPA_CNT_W-1:0]   cnt_q;
  logic                    clk_gate;
  logic                    skip_decay;

  assign clk_gate   = cfg[PWPA_CFG_SHARE_CLK] & share_clk_low;
  assign skip_decay = cfg[PWPA_CFG_NO_DECAY];

  // ---------------------------------------------------------------
  // state sequencing
  // ---------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      PWPA_CH_IDLE:
        if (on_cmd && !clk_gate && !fault_off)
          state_d = PWPA_CH_RUN;
      PWPA_CH_RUN:
        if (!on_cmd || fault_off)
          state_d = PWPA_CH_STOP;
      PWPA_CH_STOP:
        if (on_cmd && cfg[PWPA_CFG_SHORT_CYCLE])
          state_d = PWPA_CH_SHORT;
        else if (stop_done)
          state_d = skip_decay ? PWPA_CH_IDLE : PWPA_CH_DECAY;
      PWPA_CH_SHORT:
        if (cnt_q == MIN_OFF_LAST)
          state_d = skip_decay ? PWPA_CH_IDLE : PWPA_CH_DECAY;
      PWPA_CH_DECAY:
        if (vout_low)
          state_d = PWPA_CH_IDLE;
      default:
        state_d = PWPA_CH_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      state_q <= PWPA_CH_IDLE;
    else
      state_q <= state_d;
  end

  // min off time counts only while short-cycled off
  always_ff @(posedge clk)
  begin
    if (srst || state_q != PWPA_CH_SHORT)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + 1'b1;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // short cycle forces an immediate off, so only run and stop drive the output
  always_ff @(posedge clk)
  begin
    if (srst)
      out_en_q <= 1'b0;
    else
      out_en_q <= (state_d == PWPA_CH_RUN || state_d == PWPA_CH_STOP) && !clk_gate;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      run_low_q <= 1'b0;
    else
      run_low_q <= !on_cmd && !cfg[PWPA_CFG_NO_RUN_LOW];
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      alert_q <= 1'b0;
    else
      alert_q <= fault_ext_low && !cfg[PWPA_CFG_ALERT_MASK];
  end

  // sticky warning: a new hit in the clearing cycle wins
  always_ff @(posedge clk)
  begin
    if (srst)
      toff_warn_q <= 1'b0;
    else if (toff_max_hit && state_q == PWPA_CH_DECAY && !skip_decay)
      toff_warn_q <= 1'b1;
    else if (clr_faults)
      toff_warn_q <= 1'b0;
  end

endmodule : pwpa_chan

// [design/pwpa_pkg.sv]
// pwpa_pkg: shared constants and types for the write-protect and addressing block.
// assumes a 20 MHz reference clock and byte-wide command codes and data.
package pwpa_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned PWPA_CLK_HZ         = 20_000_000;
  localparam int unsigned PWPA_MIN_OFF_MS     = 120;
  localparam int unsigned PWPA_MIN_OFF_CYCLES = PWPA_CLK_HZ / 1000 * PWPA_MIN_OFF_MS;
  localparam int unsigned PWPA_CNT_W          = 22;

  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] PWPA_CMD_PAGE          = 8'h00;
  localparam logic [7:0] PWPA_CMD_OPERATION     = 8'h01;
  localparam logic [7:0] PWPA_CMD_ON_OFF_CONFIG = 8'h02;
  localparam logic [7:0] PWPA_CMD_CLEAR_FAULTS  = 8'h03;
  localparam logic [7:0] PWPA_CMD_WRITE_PROTECT = 8'h10;
  localparam logic [7:0] PWPA_CMD_STORE_USER    = 8'h15;
  localparam logic [7:0] PWPA_CMD_VOUT_COMMAND  = 8'h21;
  localparam logic [7:0] PWPA_CMD_STATUS_FIRST  = 8'h78;
  localparam logic [7:0] PWPA_CMD_STATUS_LAST   = 8'h80;
  localparam logic [7:0] PWPA_CMD_CHAN_CONFIG   = 8'hD0;
  localparam logic [7:0] PWPA_CMD_GEN_CONFIG    = 8'hD1;
  localparam logic [7:0] PWPA_CMD_DEV_ADDR      = 8'hE6;
  localparam logic [7:0] PWPA_CMD_RAIL_ADDR     = 8'hFA;

  // ---------------------------------------------------------------
  // values, reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] PWPA_WP_LVL_ALL       = 8'h80;
  localparam logic [7:0] PWPA_WP_LVL_OPS       = 8'h40;
  localparam logic [7:0] PWPA_WP_LVL_CTRL      = 8'h20;
  localparam logic [7:0] PWPA_WP_WR_MASK       = 8'hE0;
  localparam logic [7:0] PWPA_ADDR_OFF         = 8'h80;
  localparam logic [6:0] PWPA_GLOBAL_ADDR_A    = 7'h5A;
  localparam logic [6:0] PWPA_GLOBAL_ADDR_B    = 7'h5B;
  localparam logic [7:0] PWPA_PAGE_CH0         = 8'h00;
  localparam logic [7:0] PWPA_PAGE_CH1         = 8'h01;
  localparam logic [7:0] PWPA_PAGE_BOTH        = 8'hFF;
  localparam logic [7:0] PWPA_RST_PAGE         = 8'h00;
  localparam logic [7:0] PWPA_RST_WP           = 8'h00;
  localparam logic [7:0] PWPA_RST_DEV_ADDR     = 8'h4F;
  localparam logic [7:0] PWPA_RST_RAIL_ADDR    = 8'h80;
  localparam logic [7:0] PWPA_RST_CHAN_CFG     = 8'h1D;
  localparam logic [7:0] PWPA_RST_GEN_CFG      = 8'h21;
  localparam logic [7:0] PWPA_RD_NONE          = 8'hFF;
  localparam int unsigned PWPA_CFG_NO_RUN_LOW  = 4;
  localparam int unsigned PWPA_CFG_SHORT_CYCLE = 3;
  localparam int unsigned PWPA_CFG_SHARE_CLK   = 2;
  localparam int unsigned PWPA_CFG_ALERT_MASK  = 1;
  localparam int unsigned PWPA_CFG_NO_DECAY    = 0;

  // ---------------------------------------------------------------
  // channel off/restart states
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    PWPA_CH_IDLE  = 5'b0_0001,
    PWPA_CH_RUN   = 5'b0_0010,
    PWPA_CH_STOP  = 5'b0_0100,
    PWPA_CH_SHORT = 5'b0_1000,
    PWPA_CH_DECAY = 5'b1_0000
  } pwpa_ch_state_t;

endpackage : pwpa_pkg

// [design/pwpa_top.sv]
// pwpa_top: command write gating, address resolution and channel configuration.
// assumes an upstream serial engine presents decoded command writes and reads
// as one-cycle strobes synchronous to REF_CLK.
//
// Contract
// - level 0x80 allows only protect, page, unlock, store
// - level 0x40 adds peak-clear, operation, clear-faults
// - level 0x20 adds on-off config and vout command
// - status bit clears pass under 0x40, 0x20, pin
// - level 0x00 allows every command write
// - protect pin high overrides level, short list
// - device address register sets address; 0x80 disables
// - global addresses 0x5A and 0x5B always answer
// - select pins form address even when ignoring resistors
// - both select pins open uses stored address
// - pin 0 open takes low four stored bits
// - pin 1 open takes high three stored bits
// - rail address maps to channel; 0x80 disables
// - rail read contention raises communication fault
// - config bit 4 stops run pin pulling low
// - config bit 3 short-cycles on, then 120ms off
// - config bit 2 disables output while clock low
// - config bit 1 masks alert for external fault
// - config bit 0 clear waits for output decay
// - config bit 0 set skips decay and warning
// - page 0x00 and 0x01 select one channel
// - page 0xFF applies writes to both channels
`timescale 1ns/1ps
module pwpa_top
  import pwpa_pkg::*;
#(
  parameter int unsigned NUM_CH         = 2,
  parameter int unsigned MIN_OFF_CYCLES = PWPA_MIN_OFF_CYCLES,
  parameter logic [7:0]  EE_UNLOCK_CODE = 8'hBD,
  parameter logic [7:0]  PEAK_CLR_CODE  = 8'hE3
)
(
  input  wire logic                  REF_CLK,
  input  wire logic                  SRST,
  input  wire logic                  WP_PIN,
  input  wire logic                  ADDR_SELECT_PIN0_OPEN,
  input  wire logic [3:0]            ADDR_SELECT_PIN0_VAL,
  input  wire logic                  ADDR_SELECT_PIN1_OPEN,
  input  wire logic [2:0]            ADDR_SELECT_PIN1_VAL,
  input  wire logic                  CMD_WR,
  input  wire logic [6:0]            CMD_ADDR,
  input  wire logic [7:0]            CMD_CODE,
  input  wire logic [7:0]            CMD_DATA,
  input  wire logic                  RD_REQ,
  input  wire logic [6:0]            RD_ADDR,
  input  wire logic [7:0]            RD_CODE,
  input  wire logic                  RD_CONTEND,
  input  wire logic [NUM_CH-1:0]     CH_ON_CMD,
  input  wire logic [NUM_CH-1:0]     CH_FAULT_OFF,
  input  wire logic [NUM_CH-1:0]     CH_STOP_DONE,
  input  wire logic [NUM_CH-1:0]     CH_VOUT_LOW,
  input  wire logic                  SHARE_CLK_LOW,
  input  wire logic [NUM_CH-1:0]     CH_FAULT_EXT_LOW,
  input  wire logic [NUM_CH-1:0]     CH_TOFF_MAX_HIT,
  output logic                       CMD_ACK,
  output logic                       CMD_BLOCKED,
  output logic                       FWD_VALID,
  output logic [7:0]                 FWD_CODE,
  output logic [7:0]                 FWD_DATA,
  output logic [NUM_CH-1:0]          FWD_CH_MASK,
  output logic                       RD_VALID,
  output logic [7:0]                 RD_DATA,
  output logic [6:0]                 EFF_ADDR,
  output logic                       CML_FAULT,
  output logic [NUM_CH-1:0]          CH_OUT_EN,
  output logic [NUM_CH-1:0]          CH_RUN_LOW,
  output logic [NUM_CH-1:0]          CH_ALERT,
  output logic [NUM_CH-1:0]          CH_TOFF_WARN
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0]        page_q;
  logic [7:0]        wp_lvl_q;
  logic [7:0]        dev_addr_q;
  logic [7:0]        gen_cfg_q;
  logic [7:0]        rail_addr_q [NUM_CH];
  logic [7:0]        chan_cfg_q  [NUM_CH];
  logic [6:0]        eff_addr_d;
  logic              dev_hit;
  logic              global_hit;
  logic [NUM_CH-1:0] rail_hit;
  logic [NUM_CH-1:0] rd_rail_hit;
  logic [NUM_CH-1:0] page_mask;
  logic [NUM_CH-1:0] wr_mask;
  logic              addr_hit;
  logic              allowed;
  logic              wr_go;
  logic              rail_rd_q;
  logic              clr_faults;
  int unsigned       rd_ch;

  // ---------------------------------------------------------------
  // write protection
  // ---------------------------------------------------------------
  // fault clears through status commands survive the milder levels and the pin;
  // the strictest level lists none of them, so they are refused there
  function automatic logic wr_allowed(input logic [7:0] code,
                                      input logic [7:0] lvl,
                                      input logic       pin);
    logic base;
    logic ops;
    logic ctrl;
    logic status;
    base   = code == PWPA_CMD_WRITE_PROTECT || code == PWPA_CMD_PAGE ||
             code == EE_UNLOCK_CODE;
    ops    = code == PEAK_CLR_CODE || code == PWPA_CMD_OPERATION ||
             code == PWPA_CMD_CLEAR_FAULTS;
    ctrl   = code == PWPA_CMD_ON_OFF_CONFIG || code == PWPA_CMD_VOUT_COMMAND;
    status = code >= PWPA_CMD_STATUS_FIRST && code <= PWPA_CMD_STATUS_LAST;
    if (pin)
      wr_allowed = base || ops || status;
    else if (lvl[7])
      wr_allowed = base || code == PWPA_CMD_STORE_USER;
    else if (lvl[6])
      wr_allowed = base || ops || status || code == PWPA_CMD_STORE_USER;
    else if (lvl[5])
      wr_allowed = base || ops || ctrl || status || code == PWPA_CMD_STORE_USER;
    else
      wr_allowed = 1'b1;
  endfunction : wr_allowed

  // ---------------------------------------------------------------
  // address resolution
  // ---------------------------------------------------------------
  // select pins are honoured whatever the general config says about resistors
  assign eff_addr_d = {ADDR_SELECT_PIN1_OPEN ? dev_addr_q[6:4] : ADDR_SELECT_PIN1_VAL,
                       ADDR_SELECT_PIN0_OPEN ? dev_addr_q[3:0] : ADDR_SELECT_PIN0_VAL};

  assign dev_hit    = dev_addr_q != PWPA_ADDR_OFF && CMD_ADDR == eff_addr_d;
  assign global_hit = CMD_ADDR == PWPA_GLOBAL_ADDR_A ||
                      CMD_ADDR == PWPA_GLOBAL_ADDR_B;

  // a rail address steers paged writes and the forward mask only to the channel that owns it
  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_rail
    assign rail_hit[c]    = rail_addr_q[c] != PWPA_ADDR_OFF &&
                            CMD_ADDR == rail_addr_q[c][6:0];
    assign rd_rail_hit[c] = rail_addr_q[c] != PWPA_ADDR_OFF &&
                            RD_ADDR == rail_addr_q[c][6:0];
  end : g_rail

  always_comb
  begin
    page_mask = '0;
    if (page_q == PWPA_PAGE_BOTH)
      page_mask = '1;
    else if (page_q == PWPA_PAGE_CH0)
      page_mask[0] = 1'b1;
    else if (page_q == PWPA_PAGE_CH1)
      page_mask[NUM_CH-1] = 1'b1;
  end

  assign addr_hit   = dev_hit || global_hit || (|rail_hit);
  assign wr_mask    = (dev_hit || global_hit) ? page_mask : rail_hit;
  assign allowed    = wr_allowed(CMD_CODE, wp_lvl_q, WP_PIN);
  assign wr_go      = CMD_WR && addr_hit && allowed;
  assign clr_faults = wr_go && CMD_CODE == PWPA_CMD_CLEAR_FAULTS;

  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
      EFF_ADDR <= PWPA_RST_DEV_ADDR[6:0];
    else
      EFF_ADDR <= eff_addr_d;
  end

  // ---------------------------------------------------------------
  // unpaged registers
  // ---------------------------------------------------------------
  // page is not changed by a rail-addressed write, which targets a fixed channel
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
      page_q <= PWPA_RST_PAGE;
    else if (wr_go && !(|rail_hit && !dev_hit && !global_hit) &&
             CMD_CODE == PWPA_CMD_PAGE)
      page_q <= CMD_DATA;
  end

  // reserved low bits of the protect level are stored as zero
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
      wp_lvl_q <= PWPA_RST_WP;
    else if (wr_go && CMD_CODE == PWPA_CMD_WRITE_PROTECT)
      wp_lvl_q <= CMD_DATA & PWPA_WP_WR_MASK;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
      dev_addr_q <= PWPA_RST_DEV_ADDR;
    else if (wr_go && CMD_CODE == PWPA_CMD_DEV_ADDR)
      dev_addr_q <= CMD_DATA;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
      gen_cfg_q <= PWPA_RST_GEN_CFG;
    else if (wr_go && CMD_CODE == PWPA_CMD_GEN_CONFIG)
      gen_cfg_q <= CMD_DATA;
  end

  // ---------------------------------------------------------------
  // paged registers and channels
  // ---------------------------------------------------------------
  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_ch
    always_ff @(posedge REF_CLK)
    begin
      if (SRST)
        rail_addr_q[c] <= PWPA_RST_RAIL_ADDR;
      else if (wr_go && wr_mask[c] && CMD_CODE == PWPA_CMD_RAIL_ADDR)
        rail_addr_q[c] <= CMD_DATA;
    end

    always_ff @(posedge REF_CLK)
    begin
      if (SRST)
        chan_cfg_q[c] <= PWPA_RST_CHAN_CFG;
      else if (wr_go && wr_mask[c] && CMD_CODE == PWPA_CMD_CHAN_CONFIG)
        chan_cfg_q[c] <= CMD_DATA;
    end

    pwpa_chan #(
      .MIN_OFF_CYCLES (MIN_OFF_CYCLES)
    ) u_chan (
      .clk           (REF_CLK),
      .srst          (SRST),
      .cfg           (chan_cfg_q[c]),
      .on_cmd        (CH_ON_CMD[c]),
      .fault_off     (CH_FAULT_OFF[c]),
      .stop_done     (CH_STOP_DONE[c]),
      .vout_low      (CH_VOUT_LOW[c]),
      .share_clk_low (SHARE_CLK_LOW),
      .fault_ext_low (CH_FAULT_EXT_LOW[c]),
      .toff_max_hit  (CH_TOFF_MAX_HIT[c]),
      .clr_faults    (clr_faults),
      .out_en_q      (CH_OUT_EN[c]),
      .run_low_q     (CH_RUN_LOW[c]),
      .alert_q       (CH_ALERT[c]),
      .toff_warn_q   (CH_TOFF_WARN[c]),
      .state_q       ()
    );
  end : g_ch

  // ---------------------------------------------------------------
  // write answers and forwarding
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      CMD_ACK     <= 1'b0;
      CMD_BLOCKED <= 1'b0;
    end
    else
    begin
      CMD_ACK     <= wr_go;
      CMD_BLOCKED <= CMD_WR && addr_hit && !allowed;
    end
  end

  // commands not held here go on downstream with their channel mask
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      FWD_VALID   <= 1'b0;
      FWD_CODE    <= 8'h00;
      FWD_DATA    <= 8'h00;
      FWD_CH_MASK <= '0;
    end
    else
    begin
      FWD_VALID   <= wr_go && CMD_CODE != PWPA_CMD_PAGE &&
                     CMD_CODE != PWPA_CMD_WRITE_PROTECT &&
                     CMD_CODE != PWPA_CMD_DEV_ADDR && CMD_CODE != PWPA_CMD_GEN_CONFIG &&
                     CMD_CODE != PWPA_CMD_RAIL_ADDR && CMD_CODE != PWPA_CMD_CHAN_CONFIG;
      FWD_CODE    <= CMD_CODE;
      FWD_DATA    <= CMD_DATA;
      FWD_CH_MASK <= wr_mask;
    end
  end

  // ---------------------------------------------------------------
  // reads and rail contention
  // ---------------------------------------------------------------
  // page 0xFF reads channel 0; reading that way is discouraged anyway
  always_comb
  begin
    rd_ch = 0;
    if (|rd_rail_hit && !rd_rail_hit[0])
      rd_ch = NUM_CH - 1;
    else if (!(|rd_rail_hit) && page_q == PWPA_PAGE_CH1)
      rd_ch = NUM_CH - 1;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      RD_VALID <= 1'b0;
      RD_DATA  <= 8'h00;
    end
    else
    begin
      RD_VALID <= RD_REQ;
      if (RD_REQ)
      begin
        unique case (RD_CODE)
          PWPA_CMD_PAGE:          RD_DATA <= page_q;
          PWPA_CMD_WRITE_PROTECT: RD_DATA <= wp_lvl_q;
          PWPA_CMD_DEV_ADDR:      RD_DATA <= dev_addr_q;
          PWPA_CMD_GEN_CONFIG:    RD_DATA <= gen_cfg_q;
          PWPA_CMD_RAIL_ADDR:     RD_DATA <= rail_addr_q[rd_ch];
          PWPA_CMD_CHAN_CONFIG:   RD_DATA <= chan_cfg_q[rd_ch];
          default:                RD_DATA <= PWPA_RD_NONE;
        endcase
      end
    end
  end

  // the host is expected never to read through the rail address; if it does,
  // a bit mismatch seen while answering flags a communication fault
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
      rail_rd_q <= 1'b0;
    else if (RD_REQ)
      rail_rd_q <= |rd_rail_hit;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
      CML_FAULT <= 1'b0;
    else if (RD_CONTEND && rail_rd_q)
      CML_FAULT <= 1'b1;
    else if (clr_faults)
      CML_FAULT <= 1'b0;
  end

endmodule : pwpa_top

// [tb/pwpa_host.sv]
// pwpa_host: host model issuing decoded command writes and reads.
// assumes registered one-cycle answers from the device side.
`timescale 1ns/1ps
module pwpa_host
(
  input wire logic       REF_CLK, CMD_ACK, CMD_BLOCKED, RD_VALID,
  input wire logic [7:0] RD_DATA,
  output logic           CMD_WR, RD_REQ,
  output logic [6:0]     CMD_ADDR, RD_ADDR,
  output logic [7:0]     CMD_CODE, CMD_DATA, RD_CODE
);
  initial
  begin
    {CMD_WR, RD_REQ, CMD_ADDR, RD_ADDR, CMD_CODE, CMD_DATA, RD_CODE} = '0;
  end
  // only command writes go to a rail address; reads there are a test's choice
  task automatic wr(input logic [6:0] a, input logic [7:0] c, dd, output logic [1:0] r);
    @(posedge REF_CLK);
    #1;
    CMD_WR = 1'b1;
    CMD_ADDR = a;
    CMD_CODE = c;
    CMD_DATA = dd;
    @(posedge REF_CLK);
    #1;
    r = {CMD_ACK, CMD_BLOCKED};
    CMD_WR = 1'b0;
    CMD_DATA = ~dd;
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] c, output logic [7:0] q);
    @(posedge REF_CLK);
    #1;
    RD_REQ = 1'b1;
    RD_ADDR = a;
    RD_CODE = c;
    @(posedge REF_CLK);
    #1;
    q = (RD_VALID === 1'b1) ? RD_DATA : 8'hxx;
    RD_REQ = 1'b0;
    RD_CODE = ~c;
  endtask : rd
endmodule : pwpa_host

// [tb/pwpa_top_props.sv]
// pwpa_top_props: port-level checker for pwpa_top, attached by bind.
// assumes synchronous active-high SRST on REF_CLK.
`timescale 1ns/1ps
module pwpa_props_chk
  import pwpa_pkg::*;
(
  input wire logic       REF_CLK, SRST, WP_PIN, ADDR_SELECT_PIN0_OPEN, ADDR_SELECT_PIN1_OPEN,
  input wire logic [3:0] ADDR_SELECT_PIN0_VAL,
  input wire logic [2:0] ADDR_SELECT_PIN1_VAL,
  input wire logic       CMD_WR, RD_REQ, CMD_ACK, CMD_BLOCKED, FWD_VALID, RD_VALID,
  input wire logic [6:0] CMD_ADDR, EFF_ADDR,
  input wire logic [7:0] CMD_CODE
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  // ---------------------------------------------------------------
  // sequences and properties
  // ---------------------------------------------------------------
  sequence s_glob_wr;
    CMD_WR && (CMD_ADDR == PWPA_GLOBAL_ADDR_A || CMD_ADDR == PWPA_GLOBAL_ADDR_B);
  endsequence
  sequence s_answer;
    CMD_ACK ^ CMD_BLOCKED;
  endsequence
  property p_global;
    s_glob_wr |=> s_answer;
  endproperty
  property p_pin;
    s_glob_wr and (WP_PIN && CMD_CODE == PWPA_CMD_CHAN_CONFIG) |=> CMD_BLOCKED;
  endproperty
  property p_page;
    s_glob_wr and (CMD_CODE == PWPA_CMD_PAGE) |=> CMD_ACK;
  endproperty
  property p_addr;
    !ADDR_SELECT_PIN0_OPEN && !ADDR_SELECT_PIN1_OPEN |=> EFF_ADDR == {$past(ADDR_SELECT_PIN1_VAL), $past(ADDR_SELECT_PIN0_VAL)};
  endproperty
  property p_blk_fwd;
    CMD_BLOCKED |-> !FWD_VALID && !CMD_ACK;
  endproperty
  property p_quiet;
    !CMD_WR |=> !CMD_ACK && !CMD_BLOCKED;
  endproperty
  property p_rd_ans;
    RD_REQ |=> RD_VALID;
  endproperty
  property p_rd_cause;
    RD_VALID |-> $past(RD_REQ);
  endproperty
  a_global: assert property (p_global)
    else $error("global address write got no answer");
  a_pin: assert property (p_pin)
    else $error("config write passed while protect pin high");
  a_page: assert property (p_page)
    else $error("page write refused");
  a_addr: assert property (p_addr)
    else $error("effective address does not follow select pins");
  a_blk_fwd: assert property (p_blk_fwd)
    else $error("blocked write was forwarded or acknowledged");
  a_quiet: assert property (p_quiet)
    else $error("write answer without a write");
  a_rd_ans: assert property (p_rd_ans)
    else $error("read got no answer");
  a_rd_cause: assert property (p_rd_cause)
    else $error("read answer without a read");
endmodule : pwpa_props_chk

bind pwpa_top pwpa_props_chk i_chk (.*);

// [tb/tb_pmbus_write_protect_addressing.sv]
// tb_pmbus_write_protect_addressing: self-checking bench for pwpa_top.
// assumes pwpa_host drives the command side; short min-off count.
`timescale 1ns/1ps
module tb_pmbus_write_protect_addressing;
  import pwpa_pkg::*;
  logic REF_CLK = 1'b0, SRST = 1'b1, WP_PIN = 1'b0, RD_CONTEND = 1'b0, SHARE_CLK_LOW = 1'b0;
  logic ADDR_SELECT_PIN0_OPEN = 1'b1, ADDR_SELECT_PIN1_OPEN = 1'b1;
  logic [3:0] ADDR_SELECT_PIN0_VAL = 4'h3;
  logic [2:0] ADDR_SELECT_PIN1_VAL = 3'h2;
  logic [1:0] CH_ON_CMD = '0, CH_STOP_DONE = '0, CH_FAULT_OFF = '0, CH_VOUT_LOW = '0;
  logic [1:0] CH_FAULT_EXT_LOW = '0, CH_TOFF_MAX_HIT = '0;
  logic CMD_WR, RD_REQ, CMD_ACK, CMD_BLOCKED, FWD_VALID, RD_VALID, CML_FAULT;
  logic [6:0] CMD_ADDR, RD_ADDR, EFF_ADDR;
  logic [7:0] CMD_CODE, CMD_DATA, RD_CODE, RD_DATA, FWD_CODE, FWD_DATA, d, ec;
  logic [1:0] FWD_CH_MASK, CH_OUT_EN, CH_RUN_LOW, CH_ALERT, CH_TOFF_WARN, r;
  int err_total = 0, checks = 0;
  localparam logic [7:0] LV [5] = '{8'h80, 8'h40, 8'h20, 8'h00, 8'h00};
  localparam logic [7:0] CD [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h15, 8'h21, 8'h78,
                                     8'hD0, 8'hBD, 8'hE3};
  localparam logic [7:0] RC [6] = '{8'h10, 8'hE6, 8'hD0, 8'hD1, 8'hFA, 8'h00};
  localparam logic [7:0] RV [6] = '{8'h00, 8'h4F, 8'h1D, 8'h21, 8'h80, 8'h00};

  always #25 REF_CLK = ~REF_CLK;
  // short min-off count keeps the short-cycle wait within the run
  pwpa_top #(.MIN_OFF_CYCLES(20)) i_dut (.*);
  pwpa_host i_host (.*);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic ok(input logic [7:0] l, c, input logic p);
    logic b, s;
    b = c == 8'h10 || c == 8'h00 || c == 8'hBD;
    s = c inside {8'h01, 8'h03, 8'hE3, 8'h78};
    if (p) return b || s;
    if (l[7]) return b || c == 8'h15;
    if (l[6]) return b || s || c == 8'h15;
    if (l[5]) return b || s || c inside {8'h15, 8'h02, 8'h21};
    return 1'b1;
  endfunction : ok
  task automatic chk(input logic [7:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic w(input logic [6:0] a, input logic [7:0] c, dd, input logic [1:0] e);
    i_host.wr(a, c, dd, r);
    chk({6'h0, r}, {6'h0, e});
  endtask : w
  task automatic rc(input logic [6:0] a, input logic [7:0] c, e);
    i_host.rd(a, c, d);
    chk(d, e);
  endtask : rc
  task automatic tk(input int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask : tk
  task automatic stop_test;
    $display("errors %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    tk(5);
    SRST = 1'b0;
    foreach (RC[i]) rc(7'h5A, RC[i], RV[i]);
    chk({1'b0, EFF_ADDR}, 8'h4F);
    CH_ON_CMD = 2'b11;
    tk(3);
    chk({6'h0, CH_OUT_EN}, 8'h03);
    SHARE_CLK_LOW = 1'b1;
    tk(3);
    chk({6'h0, CH_OUT_EN}, 8'h00);
    SHARE_CLK_LOW = 1'b0;
    CH_ON_CMD = 2'b00;
    tk(3);
    chk({6'h0, CH_RUN_LOW}, 8'h00);
    CH_ON_CMD = 2'b11;
    tk(3);
    chk({6'h0, CH_OUT_EN}, 8'h00);
    tk(30);
    chk({6'h0, CH_OUT_EN}, 8'h03);
    CH_ON_CMD = 2'b00;
    {CH_STOP_DONE, CH_TOFF_MAX_HIT} = 4'hF;
    tk(3);
    {CH_STOP_DONE, CH_TOFF_MAX_HIT} = 4'h0;
    chk({6'h0, CH_TOFF_WARN}, 8'h00);
    ec = 8'h1D;
    foreach (LV[i])
    begin
      WP_PIN = (i == 4);
      w(7'h5A, 8'h10, LV[i], 2'b10);
      foreach (CD[j])
      begin
        d = (CD[j] == 8'hD0) ? ~LV[i] : 8'h00;
        w(7'h5A, CD[j], d, ok(LV[i], CD[j], WP_PIN) ? 2'b10 : 2'b01);
        ec = (CD[j] == 8'hD0 && ok(LV[i], CD[j], WP_PIN)) ? d : ec;
      end
      rc(7'h5A, 8'hD0, ec);
    end
    WP_PIN = 1'b0;
    w(7'h5A, 8'h10, 8'h00, 2'b10);
    {ADDR_SELECT_PIN0_OPEN, ADDR_SELECT_PIN1_OPEN} = 2'b00;
    tk(2);
    w(7'h23, 8'h10, 8'h00, 2'b10);
    ADDR_SELECT_PIN1_OPEN = 1'b1;
    tk(2);
    chk({1'b0, EFF_ADDR}, 8'h43);
    {ADDR_SELECT_PIN0_OPEN, ADDR_SELECT_PIN1_OPEN} = 2'b10;
    tk(2);
    chk({1'b0, EFF_ADDR}, 8'h2F);
    ADDR_SELECT_PIN1_OPEN = 1'b1;
    w(7'h5A, 8'hE6, 8'h80, 2'b10);
    w(7'h4F, 8'h10, 8'h00, 2'b00);
    w(7'h5B, 8'hE6, 8'h4F, 2'b10);
    w(7'h4F, 8'h10, 8'h00, 2'b10);
    w(7'h5A, 8'hFA, 8'h30, 2'b10);
    w(7'h30, 8'hD0, 8'h05, 2'b10);
    rc(7'h5A, 8'hD0, 8'h05);
    w(7'h5A, 8'h00, 8'h01, 2'b10);
    rc(7'h5A, 8'hD0, 8'h1D);
    w(7'h5A, 8'h00, 8'hFF, 2'b10);
    w(7'h5A, 8'hD0, 8'h0C, 2'b10);
    w(7'h5A, 8'h00, 8'h01, 2'b10);
    rc(7'h5A, 8'hD0, 8'h0C);
    rc(7'h30, 8'hD0, 8'h0C);
    RD_CONTEND = 1'b1;
    tk(1);
    RD_CONTEND = 1'b0;
    tk(1);
    chk({7'h0, CML_FAULT}, 8'h01);
    w(7'h5A, 8'h03, 8'h00, 2'b10);
    tk(1);
    chk({7'h0, CML_FAULT}, 8'h00);
    w(7'h5A, 8'h00, 8'h00, 2'b10);
    w(7'h5A, 8'hFA, 8'h80, 2'b10);
    w(7'h30, 8'hD0, 8'h00, 2'b00);
    chk({6'h0, CH_RUN_LOW}, 8'h03);
    w(7'h5A, 8'hD0, 8'h02, 2'b10);
    CH_FAULT_EXT_LOW = 2'b11;
    tk(2);
    chk({6'h0, CH_ALERT}, 8'h02);
    CH_ON_CMD = 2'b01;
    tk(2);
    {CH_ON_CMD, CH_STOP_DONE} = 4'b0001;
    tk(2);
    {CH_STOP_DONE, CH_TOFF_MAX_HIT, CH_ON_CMD} = 6'h05;
    tk(2);
    chk({6'h0, CH_OUT_EN}, 8'h00);
    chk({6'h0, CH_TOFF_WARN}, 8'h01);
    {CH_TOFF_MAX_HIT, CH_VOUT_LOW} = 4'h1;
    tk(3);
    chk({6'h0, CH_OUT_EN}, 8'h01);
    w(7'h5A, 8'h03, 8'h00, 2'b10);
    chk({5'h0, FWD_VALID, FWD_CH_MASK}, 8'h05);
    chk(FWD_CODE, 8'h03);
    chk({6'h0, CH_TOFF_WARN}, 8'h00);
    stop_test();
  end
  initial
  begin
    #400_000;
    err_total++;
    stop_test();
  end
endmodule : tb_pmbus_write_protect_addressing
